// File: src/afms_device.sv
// afms_device: converter-side mode sequencer with result fifo
// assumes: analog result arrives on sample_in when convert accepted
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module afms_device
    import afms_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH_MAX
)(
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    afms_if.device                            bus,
    input  wire logic [afms_pkg::DATA_W-1:0]  sample_in,
    output logic                              conv_go,
    output logic [afms_pkg::CHAN_W-1:0]       conv_chan
);
    import afms_pkg::*;

    logic [1:0]                  mode_q;
    logic [DEPTH_W-1:0]          depth_q;
    logic [4*CHAN_W-1:0]         order_q;
    logic [CHAN_W-1:0]           chan_q;
    logic                        chan_sel_q;
    logic [1:0]                  seq_idx_q;
    logic [DATA_W-1:0]           mem_q [DEPTH];
    logic [DEPTH_W-1:0]          count_q;
    logic [DEPTH_W-1:0]          rd_ptr_q;
    logic                        sweep_done_q;

    logic          is_cmd;
    logic          cfg_wr;
    logic          cfg_rd;
    logic          sel;
    logic          fifo_rd;
    logic          conv;
    logic          full;
    logic          conv_ok;
    logic          restart;
    logic          store;
    logic [CHAN_W-1:0] conv_target;

    assign is_cmd  = bus.cmd_valid;
    assign cfg_wr  = is_cmd && bus.cmd_code == AFMS_CMD_CFG_WRITE;
    assign cfg_rd  = is_cmd && bus.cmd_code == AFMS_CMD_CFG_READ;
    assign sel     = is_cmd && bus.cmd_code == AFMS_CMD_SELECT;
    assign fifo_rd = is_cmd && bus.cmd_code == AFMS_CMD_FIFO_READ;
    assign conv    = is_cmd && bus.cmd_code == AFMS_CMD_CONVERT;
    assign full    = count_q >= depth_q;

    // sweep modes take their channel from the order, others need a selection
    always_comb
    begin
        conv_ok = 1'b0;
        restart = 1'b0;
        unique case (mode_q)
            MODE_SINGLE, MODE_REPEAT: conv_ok = chan_sel_q && !(mode_q == MODE_REPEAT && full);
            MODE_SWEEP:        conv_ok = !full && !sweep_done_q;
            MODE_REPEAT_SWEEP:
            begin
                conv_ok = 1'b1;
                restart = full;
            end
        endcase
    end

    assign conv_target = (mode_q[1]) ? order_q[(restart ? 2'd0 : seq_idx_q)*CHAN_W +: CHAN_W] : chan_q;
    assign store       = conv && conv_ok && mode_q != MODE_SINGLE;

    // configuration
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mode_q  <= RST_MODE;
            depth_q <= RST_DEPTH;
            order_q <= '0;
        end
        else if (cfg_wr)
        begin
            mode_q  <= bus.cmd_data[CTRL_MODE_LSB +: 2];
            depth_q <= (bus.cmd_data[CTRL_DEPTH_LSB +: DEPTH_W] > DEPTH_W'(DEPTH)) ? DEPTH_W'(DEPTH)
                       : bus.cmd_data[CTRL_DEPTH_LSB +: DEPTH_W];
            order_q <= bus.cmd_data[CMD_DATA_LSB +: 4*CHAN_W];
        end
    end

    // channel selection; consumed by reconfiguration so it must be redone
    always_ff @(posedge clk)
    begin
        if (sys_rst || cfg_wr)
            chan_sel_q <= 1'b0;
        else if (sel)
            chan_sel_q <= 1'b1;
        else if (mode_q == MODE_REPEAT && fifo_rd && count_q == DEPTH_W'(1) && rd_ptr_q == count_q - DEPTH_W'(1))
            chan_sel_q <= chan_sel_q;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            chan_q <= '0;
        else if (sel)
            chan_q <= bus.cmd_data[CMD_CHAN_LSB +: CHAN_W];
    end

    // sweep position and end of sweep
    always_ff @(posedge clk)
    begin
        if (sys_rst || cfg_wr)
        begin
            seq_idx_q    <= '0;
            sweep_done_q <= 1'b0;
        end
        else if (conv && conv_ok && mode_q[1])
        begin
            seq_idx_q    <= restart ? 2'd1 : seq_idx_q + 2'd1;
            sweep_done_q <= !restart && (count_q + DEPTH_W'(1) >= depth_q) && mode_q == MODE_SWEEP;
        end
        else if (fifo_rd && rd_ptr_q + DEPTH_W'(1) >= count_q && count_q != '0)
        begin
            seq_idx_q    <= '0;
            sweep_done_q <= 1'b0;
        end
    end

    // fifo storage and count
    always_ff @(posedge clk)
    begin
        if (sys_rst || cfg_wr)
        begin
            count_q  <= '0;
            rd_ptr_q <= '0;
        end
        else if (store && restart)
        begin
            count_q  <= DEPTH_W'(1);
            rd_ptr_q <= '0;
        end
        else if (store)
            count_q <= count_q + DEPTH_W'(1);
        else if (fifo_rd && count_q != '0)
        begin
            if (rd_ptr_q + DEPTH_W'(1) >= count_q)
            begin
                rd_ptr_q <= '0; // whole fifo read, empty it
                count_q  <= '0;
            end
            else
                rd_ptr_q <= rd_ptr_q + DEPTH_W'(1);
        end
    end

    generate
        for (genvar i = 0; i < DEPTH; i++)
        begin : g_mem
            always_ff @(posedge clk)
            begin
                if (store && DEPTH_W'(i) == (restart ? DEPTH_W'(0) : count_q))
                    mem_q[i] <= sample_in;
            end
        end
    endgenerate

    // answers to the host
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus.rsp_valid   <= 1'b0;
            bus.rsp_data    <= '0;
            bus.rsp_refused <= 1'b0;
            conv_go         <= 1'b0;
            conv_chan       <= '0;
        end
        else
        begin
            bus.rsp_valid   <= (conv && conv_ok && mode_q == MODE_SINGLE) || fifo_rd || cfg_rd;
            bus.rsp_refused <= conv && !conv_ok;
            conv_go         <= conv && conv_ok;
            conv_chan       <= conv_target;
            if (conv && mode_q == MODE_SINGLE)
                bus.rsp_data <= sample_in;
            else if (fifo_rd)
                bus.rsp_data <= (count_q != '0) ? mem_q[rd_ptr_q[$clog2(DEPTH)-1:0]] : '0;
            else if (cfg_rd)
                bus.rsp_data <= DATA_W'({depth_q, 2'h0, mode_q});
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus.fifo_full  <= 1'b0;
            bus.fifo_count <= '0;
        end
        else
        begin
            bus.fifo_full  <= full && mode_q != MODE_SINGLE;
            bus.fifo_count <= count_q;
        end
    end
endmodule : afms_device
`default_nettype wire

// File: src/afms_pkg.sv
// afms_pkg: shared constants and types for the adc fifo mode sequencer
// assumes: both ends compile against this package before the interface
package afms_pkg;
    localparam int FIFO_DEPTH_MAX = 8;
    localparam int CHAN_W         = 4;
    localparam int DATA_W         = 12;
    localparam int DEPTH_W        = 4;

    // conversion mode codes
    localparam logic [1:0] MODE_SINGLE      = 2'h0;
    localparam logic [1:0] MODE_REPEAT      = 2'h1;
    localparam logic [1:0] MODE_SWEEP       = 2'h2;
    localparam logic [1:0] MODE_REPEAT_SWEEP = 2'h3;

    // command codes on the command channel
    typedef enum logic [2:0] {
        AFMS_CMD_NONE      = 3'h0,
        AFMS_CMD_CFG_WRITE = 3'h1,
        AFMS_CMD_CFG_READ  = 3'h2,
        AFMS_CMD_SELECT    = 3'h3,
        AFMS_CMD_FIFO_READ = 3'h4,
        AFMS_CMD_CONVERT   = 3'h5
    } afms_cmd_t;

    // controller register offsets (word index on the software port)
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_ORDER    = 4'h1;
    localparam logic [3:0] REG_CMD      = 4'h2;
    localparam logic [3:0] REG_RESULT   = 4'h3;
    localparam logic [3:0] REG_STATUS   = 4'h4;
    localparam logic [3:0] REG_IRQ_STAT = 4'h5;
    localparam logic [3:0] REG_IRQ_MASK = 4'h6;

    // ctrl and command field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_DEPTH_LSB = 4;
    localparam int CMD_CODE_LSB   = 0;
    localparam int CMD_CHAN_LSB   = 4;
    localparam int CMD_DATA_LSB   = 8;

    // irq status bits
    localparam int IRQ_RESULT = 0;
    localparam int IRQ_THRESH = 1;
    localparam int IRQ_REFUSE = 2;
    localparam int IRQ_W      = 3;

    localparam logic [1:0]         RST_MODE  = 2'h0;
    localparam logic [DEPTH_W-1:0] RST_DEPTH = 4'h4;
endpackage : afms_pkg

// File: src/afms_if.sv
// afms_if: command/answer channel between host controller and converter
// assumes: one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface afms_if
    import afms_pkg::*;
(
    input wire logic clk
);
    logic                 cmd_valid;
    afms_cmd_t            cmd_code;
    logic [31:0]          cmd_data;
    logic                 rsp_valid;
    logic [DATA_W-1:0]    rsp_data;
    logic                 rsp_refused;
    logic                 fifo_full;
    logic [DEPTH_W-1:0]   fifo_count;

    modport device (input cmd_valid, cmd_code, cmd_data,
                    output rsp_valid, rsp_data, rsp_refused, fifo_full, fifo_count);
    modport host   (output cmd_valid, cmd_code, cmd_data,
                    input rsp_valid, rsp_data, rsp_refused, fifo_full, fifo_count);
endinterface : afms_if
`default_nettype wire

// File: src/afms_host.sv
// afms_host: host controller issuing commands from a software register port
// assumes: software follows the documented mode sequences
`timescale 1ns/1ps
`default_nettype none
module afms_host
    import afms_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           sys_rst,
    afms_if.host                bus,
    input  wire logic [3:0]     reg_addr,
    input  wire logic [31:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic [31:0]         reg_rdata,
    output logic                irq
);
    import afms_pkg::*;

    logic [31:0]        ctrl_q;
    logic [15:0]        order_q;
    logic [DATA_W-1:0]  result_q;
    logic [IRQ_W-1:0]   irq_stat_q;
    logic [IRQ_W-1:0]   irq_mask_q;
    logic [IRQ_W-1:0]   ev;

    // a command write sends one command; config carries ctrl and order
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bus.cmd_valid <= 1'b0;
            bus.cmd_code  <= AFMS_CMD_NONE;
            bus.cmd_data  <= '0;
        end
        else
        begin
            bus.cmd_valid <= reg_wr && reg_addr == REG_CMD;
            bus.cmd_code  <= afms_cmd_t'(reg_wdata[CMD_CODE_LSB +: 3]);
            if (afms_cmd_t'(reg_wdata[CMD_CODE_LSB +: 3]) == AFMS_CMD_CFG_WRITE)
                // order rides in [23:8] beside mode and depth in [7:0]
                bus.cmd_data <= {8'h0, order_q, ctrl_q[7:0]};
            else
                bus.cmd_data <= reg_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_q  <= {24'h0, RST_DEPTH, 2'h0, RST_MODE};
            order_q <= 16'h0;
        end
        else if (reg_wr && reg_addr == REG_CTRL)
            ctrl_q <= reg_wdata;
        else if (reg_wr && reg_addr == REG_ORDER)
            order_q <= reg_wdata[15:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            result_q <= '0;
        else if (bus.rsp_valid)
            result_q <= bus.rsp_data;
    end

    assign ev = {bus.rsp_refused, bus.fifo_full, bus.rsp_valid};

    // set wins over write-one-to-clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_stat_q <= '0;
        else if (reg_wr && reg_addr == REG_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | ev;
        else
            irq_stat_q <= irq_stat_q | ev;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_mask_q <= '0;
        else if (reg_wr && reg_addr == REG_IRQ_MASK)
            irq_mask_q <= reg_wdata[IRQ_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |((irq_stat_q | ev) & irq_mask_q);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL:     reg_rdata <= ctrl_q;
                REG_ORDER:    reg_rdata <= {16'h0, order_q};
                REG_RESULT:   reg_rdata <= {20'h0, result_q};
                REG_STATUS:   reg_rdata <= {26'h0, bus.fifo_full, 1'b0, bus.fifo_count};
                REG_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_q};
                REG_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_q};
                default:      reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end
endmodule : afms_host
`default_nettype wire

// File: sim/afms_checker.sv
// afms_checker: assertions on the host/device command channel
// assumes: instantiated in testbench beside afms_if_i
`timescale 1ns/1ps
`default_nettype none
module afms_checker
    import afms_pkg::*;
(
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               cmd_valid,
    input wire afms_cmd_t          cmd_code,
    input wire logic [31:0]        cmd_data,
    input wire logic               rsp_valid,
    input wire logic               rsp_refused,
    input wire logic               fifo_full,
    input wire logic [DEPTH_W-1:0] fifo_count
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [1:0]         mode_q;
    logic [DEPTH_W-1:0] depth_q;
    wire logic          cfg_w = cmd_valid && cmd_code == AFMS_CMD_CFG_WRITE;
    wire logic          conv  = cmd_valid && cmd_code == AFMS_CMD_CONVERT;
    // shadow of the mode and depth last sent to the device
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mode_q  <= RST_MODE;
            depth_q <= RST_DEPTH;
        end
        else if (cfg_w)
        begin
            mode_q  <= cmd_data[1:0];
            depth_q <= (cmd_data[7:4] > 4'h8) ? 4'h8 : cmd_data[7:4];
        end
    end
    property p_refuse_cause;
        rsp_refused |-> $past(cmd_valid) && $past(cmd_code) inside {AFMS_CMD_CONVERT, AFMS_CMD_FIFO_READ};
    endproperty
    a_refuse_cause: assert property (p_refuse_cause) else $error("refusal without command");
    property p_sweep_ignore;
        mode_q == MODE_SWEEP && fifo_full && conv |=> rsp_refused;
    endproperty
    a_sweep_ignore: assert property (p_sweep_ignore) else $error("convert taken in full sweep");
    property p_rsweep_restart;
        mode_q == MODE_REPEAT_SWEEP && fifo_full && conv |=> !rsp_refused ##[0:3] !fifo_full;
    endproperty
    a_rsweep_restart: assert property (p_rsweep_restart) else $error("repeat sweep not restarted");
    property p_single_bypass;
        mode_q == MODE_SINGLE && $past(mode_q, 3) == MODE_SINGLE |-> fifo_count == 4'h0;
    endproperty
    a_single_bypass: assert property (p_single_bypass) else $error("single shot stored");
    property p_count_step;
        fifo_count > $past(fifo_count) |-> fifo_count == $past(fifo_count) + 4'h1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count jumped");
    property p_cfg_clear;
        cfg_w |-> ##[1:4] fifo_count == 4'h0;
    endproperty
    a_cfg_clear: assert property (p_cfg_clear) else $error("fifo kept over reconfig");
    property p_full_depth;
        fifo_full && !$past(cfg_w) && !$past(cfg_w, 2) |-> fifo_count == depth_q;
    endproperty
    a_full_depth: assert property (p_full_depth) else $error("full off depth");
    property p_sweep_stop;
        mode_q == MODE_SWEEP && fifo_full && !cmd_valid && !$past(cmd_valid) |=> fifo_full;
    endproperty
    a_sweep_stop: assert property (p_sweep_stop) else $error("sweep left full");
    property p_single_answer;
        mode_q == MODE_SINGLE && conv |=> rsp_valid || rsp_refused;
    endproperty
    a_single_answer: assert property (p_single_answer) else $error("single convert unanswered");
endmodule : afms_checker
`default_nettype wire

// File: sim/testbench.sv
// testbench: host and device joined by afms_if, driven on the register port
// assumes: package, interface, both ends and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import afms_pkg::*;
    logic              clk, sys_rst, reg_wr, reg_rd, irq, conv_go;
    logic              got_rsp, got_ref, got_go, clr;
    logic [3:0]        reg_addr;
    logic [31:0]       reg_wdata, reg_rdata, rd;
    logic [DATA_W-1:0] sample_in, last_rsp;
    logic [CHAN_W-1:0] conv_chan, last_chan;
    int                n_errors = 0;
    int                n_checks = 0;
    afms_if afms_if_i (.clk(clk));
    afms_host afms_host_i (.clk(clk), .sys_rst(sys_rst), .bus(afms_if_i), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    afms_device afms_device_i (.clk(clk), .sys_rst(sys_rst), .bus(afms_if_i), .sample_in(sample_in),
        .conv_go(conv_go), .conv_chan(conv_chan));
    afms_checker afms_checker_i (.clk(clk), .sys_rst(sys_rst), .cmd_valid(afms_if_i.cmd_valid),
        .cmd_code(afms_if_i.cmd_code), .cmd_data(afms_if_i.cmd_data), .rsp_valid(afms_if_i.rsp_valid),
        .rsp_refused(afms_if_i.rsp_refused), .fifo_full(afms_if_i.fifo_full), .fifo_count(afms_if_i.fifo_count));
    // sticky capture, so one-cycle answers are never missed
    always @(posedge clk)
    begin
        got_rsp <= !clr && (got_rsp || afms_if_i.rsp_valid);
        got_ref <= !clr && (got_ref || afms_if_i.rsp_refused);
        got_go  <= !clr && (got_go || conv_go);
        if (afms_if_i.rsp_valid)
            last_rsp <= afms_if_i.rsp_data;
        if (conv_go)
            last_chan <= conv_chan;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rdr
    // clears the flags at one edge, then waits out the fixed answer latency
    task automatic cmd(input afms_cmd_t c, input logic [3:0] ch, input logic [11:0] s);
        @(posedge clk);
        clr       <= 1'b1;
        sample_in <= s;
        @(posedge clk);
        clr <= 1'b0;
        wr(REG_CMD, {24'h0, ch, 1'b0, c});
        repeat (4) @(posedge clk);
        #1;
    endtask : cmd
    task automatic conv(input logic [11:0] s, input logic go, input logic [3:0] ch);
        cmd(AFMS_CMD_CONVERT, 4'h0, s);
        chk(32'(got_go), 32'(go));
        chk(32'(got_ref), 32'(!go));
        if (go)
            chk(32'(last_chan), 32'(ch));
    endtask : conv
    task automatic fread(input logic [11:0] exp);
        cmd(AFMS_CMD_FIFO_READ, 4'h0, 12'h0);
        chk(32'(got_rsp), 32'h1);
        chk(32'(last_rsp), 32'(exp));
    endtask : fread
    task automatic cfg(input logic [1:0] m, input logic [31:0] ord);
        wr(REG_CTRL, 32'h40 | 32'(m));
        wr(REG_ORDER, ord);
        cmd(AFMS_CMD_CFG_WRITE, 4'h0, 12'h0);
    endtask : cfg
    task automatic t_single;
        rdr(REG_CTRL);
        chk(rd, 32'h40);
        conv(12'h0, 1'b0, 4'h0);
        cmd(AFMS_CMD_SELECT, 4'h5, 12'h0);
        conv(12'habc, 1'b1, 4'h5);
        chk(32'(last_rsp), 32'habc);
        chk(32'(afms_if_i.fifo_count), 32'h0);
        rdr(REG_RESULT);
        chk(rd, 32'habc);
    endtask : t_single
    task automatic t_repeat;
        cfg(MODE_REPEAT, 32'h0);
        conv(12'h0, 1'b0, 4'h0);
        cmd(AFMS_CMD_SELECT, 4'h3, 12'h0);
        for (int i = 0; i < 4; i++)
        begin
            conv(12'h100 + 12'(i), 1'b1, 4'h3);
            chk(32'(afms_if_i.fifo_count), 32'(i + 1));
        end
        chk(32'(afms_if_i.fifo_full), 32'h1);
        rdr(REG_STATUS);
        chk(rd, 32'h24);
        conv(12'h0, 1'b0, 4'h0);
        for (int i = 0; i < 4; i++)
            fread(12'h100 + 12'(i));
        cmd(AFMS_CMD_SELECT, 4'h3, 12'h0);
        conv(12'h200, 1'b1, 4'h3);
        cfg(MODE_REPEAT, 32'h0);
        chk(32'(afms_if_i.fifo_count), 32'h0);
    endtask : t_repeat
    task automatic t_sweep;
        cfg(MODE_SWEEP, 32'h4321);
        for (int i = 0; i < 4; i++)
            conv(12'h300 + 12'(i), 1'b1, 4'(i + 1));
        wr(REG_IRQ_STAT, 32'h7);
        conv(12'h0, 1'b0, 4'h0);
        rdr(REG_IRQ_STAT);
        chk(rd & 32'h4, 32'h4);
        wr(REG_IRQ_MASK, 32'h0);
        rdr(REG_IRQ_MASK);
        chk(32'(irq), 32'h0);
        wr(REG_IRQ_MASK, 32'h4);
        rdr(REG_IRQ_MASK);
        chk(32'(irq), 32'h1);
        wr(REG_IRQ_STAT, 32'h4);
        rdr(REG_IRQ_STAT);
        chk(32'(irq), 32'h0);
        cmd(AFMS_CMD_CFG_READ, 4'h0, 12'h0);
        chk(32'(got_ref), 32'h0);
        chk(32'(got_rsp), 32'h1);
        chk(32'(last_rsp), 32'h42);
        for (int i = 0; i < 4; i++)
            fread(12'h300 + 12'(i));
        conv(12'h310, 1'b1, 4'h1);
    endtask : t_sweep
    task automatic t_rsweep;
        cfg(MODE_REPEAT_SWEEP, 32'h4321);
        for (int i = 0; i < 4; i++)
            conv(12'h3f0, 1'b1, 4'(i + 1));
        conv(12'h400, 1'b1, 4'h1);
        chk(32'(afms_if_i.fifo_count), 32'h1);
        for (int i = 1; i < 4; i++)
            conv(12'h400 + 12'(i), 1'b1, 4'(i + 1));
        for (int i = 0; i < 4; i++)
            fread(12'h400 + 12'(i));
        conv(12'h500, 1'b1, 4'h1);
    endtask : t_rsweep
    task automatic finish_test;
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #100000;
        n_errors++;
        finish_test();
    end
    initial
    begin
        {sys_rst, clr, reg_wr, reg_rd, reg_addr, reg_wdata, sample_in} = {4'hc, 4'h0, 32'h0, 12'h0};
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_single();
        t_repeat();
        t_sweep();
        t_rsweep();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
